/* File: rtl/motion_comp_deinterlacer.v */
// Motion-compensated deinterlacer for one 16x4 luma block
// Assumes upstream fetch supplies windows and pixels for the shown vector
`default_nettype none
`include "motion_comp_deinterlacer_defines.vh"

module motion_comp_deinterlacer (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // AXI4-Lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Block control
  input wire blkStart,
  output reg blkBusy,
  output reg blkDone,
  // Search window stream
  input wire winValid,
  output reg winReady,
  input wire [239:0] refWin,
  input wire [239:0] curWin,
  output reg [4:0] pairIdx,
  output reg [3:0] candIdx,
  output reg [7:0] fetchMv,
  // Interpolation stream
  input wire pixValid,
  output reg pixReady,
  input wire [63:0] refQuad,
  input wire [63:0] curQuad,
  input wire [31:0] oppEdge,
  input wire [31:0] vertNbr,
  input wire [15:0] sdiPix,
  input wire [15:0] tdiPix,
  input wire [7:0] motionMeasure,
  input wire angle90,
  input wire [7:0] horizCplx,
  input wire [7:0] vertCplx,
  input wire [12:0] angleCost,
  // Result stream
  output reg outValid,
  output reg [15:0] outPix,
  output reg [4:0] outPair
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEARCH = 2'h1;
  localparam [1:0] ST_INTERP = 2'h2;
  localparam [127:0] CAND_TAB = `CAND_TABLE;

  // Software and sampled parameter words
  reg [31:0] thr_r;
  reg [31:0] cat_r;
  reg [31:0] bld_r;
  reg [31:0] cThr_r;
  reg [31:0] cCat_r;
  reg [31:0] cBld_r;
  // Bus holding state
  reg awHeld_r;
  reg wHeld_r;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  // Search state
  reg [1:0] state_r;
  reg [7:0] mvTab [0:31];
  reg [7:0] pairMv_r;
  reg [12:0] pairSad_r;
  reg [12:0] blkCost_r;
  integer i;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  function [4:0] mag5;
    input [4:0] v;
    begin
      mag5 = v[4] ? (~v + 5'h01) : v;
    end
  endfunction

  function smOk;
    input [7:0] a;
    input [7:0] b;
    input useSum;
    input [1:0] th;
    reg [4:0] sx;
    reg [4:0] sy;
    begin
      sx = useSum ? ({a[7], a[7:4]} + {b[7], b[7:4]})
                  : ({a[7], a[7:4]} - {b[7], b[7:4]});
      sy = useSum ? ({a[3], a[3:0]} + {b[3], b[3:0]})
                  : ({a[3], a[3:0]} - {b[3], b[3:0]});
      smOk = (mag5(sx) <= {3'h0, th}) && (mag5(sy) <= {3'h0, th});
    end
  endfunction

  function [7:0] ad;
    input [7:0] a;
    input [7:0] b;
    begin
      ad = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function [7:0] avg2;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + 9'h001;
      avg2 = s[8:1];
    end
  endfunction

  // Slot 0 base, 1 side neighbour, 2 base next line, 3 its neighbour
  function [7:0] pick;
    input [31:0] q;
    input hOdd;
    input vOdd;
    reg [9:0] s;
    begin
      s = {2'h0, q[7:0]} + {2'h0, q[15:8]} + {2'h0, q[23:16]}
        + {2'h0, q[31:24]} + 10'h002;
      case ({vOdd, hOdd})
        2'h0: pick = q[7:0];
        2'h1: pick = avg2(q[7:0], q[15:8]);
        2'h2: pick = avg2(q[7:0], q[23:16]);
        default: pick = s[9:2];
      endcase
    end
  endfunction

  // Sampled parameter fields
  wire [5:0] consTh = cThr_r[`F_CONS +: 6];
  wire [1:0] smoothTh = cThr_r[`F_SMTH +: 2];
  wire [1:0] lowCostTh = cThr_r[`F_LCT +: 2];
  wire [3:0] tightMargin = cThr_r[`F_TGT +: 4];
  wire [3:0] nbrTh = cThr_r[`F_NBR +: 4];
  wire [3:0] slope = cCat_r[`F_SLOPE +: 4];
  wire [3:0] lowPreset = cCat_r[`F_LOWP +: 4];
  wire [3:0] highPreset = cCat_r[`F_HIGHP +: 4];
  wire [7:0] stmmMin = cBld_r[`F_SMIN +: 8];
  wire [7:0] stmmMax = cBld_r[`F_SMAX +: 8];
  wire [3:0] stmmShift = cBld_r[`F_SHIFT +: 4];

  // Motion search
  wire [12:0] sad;
  sad_window u_sad (
    .refWin(refWin),
    .curWin(curWin),
    .sad(sad)
  );

  wire [3:0] candInc = candIdx + 4'h1;
  wire [4:0] pairInc = pairIdx + 5'h01;
  wire [7:0] candMv = CAND_TAB[candIdx*8 +: 8];
  wire take = (candIdx == 4'h0) || (sad <= pairSad_r);
  wire [7:0] winMv = take ? candMv : pairMv_r;
  wire [12:0] winSad = take ? sad : pairSad_r;
  wire blkFirst = (pairIdx == 5'h00) && (candIdx == 4'h0);
  wire [12:0] blkNext = (blkFirst || sad < blkCost_r) ? sad : blkCost_r;

  // Smoothness per pair, pair index is line * 8 + column
  wire [31:0] smoothOk;
  genvar gp;
  generate
    for (gp = 0; gp < 32; gp = gp + 1) begin : g_sm
      localparam integer LN = gp / 8;
      localparam integer CL = gp % 8;
      localparam integer V1 = (LN < 2) ? gp + 8 : gp - 8;
      localparam integer V2 = (LN < 2) ? gp + 16 : gp - 16;
      localparam integer HN = (CL % 2 == 0) ? gp + 1 : gp - 1;
      assign smoothOk[gp] = smOk(mvTab[gp], mvTab[V1], 1'b1, smoothTh)
        && smOk(mvTab[gp], mvTab[V2], 1'b0, smoothTh)
        && smOk(mvTab[gp], mvTab[HN], 1'b0, smoothTh);
    end
  endgenerate

  // Content adaptive threshold
  wire [8:0] spatial_complexity = {1'b0, horizCplx} + {1'b0, vertCplx};
  wire [7:0] boundLo = slope * lowPreset;
  wire [7:0] boundHi = slope * highPreset;
  wire [8:0] scmDiv = (slope == 4'h0) ? {5'h00, highPreset}
                                      : spatial_complexity / {5'h00, slope};
  wire [8:0] contentTh = (spatial_complexity < {1'b0, boundLo}) ? {5'h00, lowPreset}
    : (spatial_complexity > {1'b0, boundHi}) ? {5'h00, highPreset} : scmDiv;
  wire [13:0] contentTh30 = contentTh * `CAT_MULT;
  wire [8:0] tight30 = tightMargin * `CAT_MULT;
  wire lowBand = blkCost_r <= {11'h000, lowCostTh};
  wire midBand = !lowBand && ({1'b0, blkCost_r} < contentTh30);
  wire tightOk = ({1'b0, blkCost_r} + {5'h00, tight30})
               < {1'b0, angleCost, 1'b0};
  wire pairSmooth = smoothOk[pairIdx];
  wire [7:0] wHi = motionMeasure - stmmMin;
  wire [7:0] wLo = stmmMax - motionMeasure;

  // Two pixels per clock
  wire [15:0] laneOut;
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl = gl + 1) begin : g_lane
      wire [7:0] oUp = oppEdge[gl*16 +: 8];
      wire [7:0] oDn = oppEdge[gl*16+8 +: 8];
      wire [7:0] vUp = vertNbr[gl*16 +: 8];
      wire [7:0] vDn = vertNbr[gl*16+8 +: 8];
      wire [7:0] sdi = sdiPix[gl*8 +: 8];
      wire [7:0] tdi = tdiPix[gl*8 +: 8];
      wire [7:0] mc = pick(refQuad[gl*32 +: 32], fetchMv[4],
                           fetchMv[1]);
      wire [7:0] dc = pick(curQuad[gl*32 +: 32], fetchMv[4],
                           fetchMv[1]);
      wire [7:0] dMc = ad(mc, dc);
      wire cons = (ad(oUp, oDn) > dMc) && (dMc < {2'h0, consTh});
      wire checks = cons && pairSmooth;
      wire [7:0] lo = (vUp < vDn) ? vUp : vDn;
      wire [7:0] hi = (vUp < vDn) ? vDn : vUp;
      wire isMed = (mc >= lo) && (mc <= hi);
      wire [7:0] dUp = ad(mc, vUp);
      wire [7:0] dDn = ad(mc, vDn);
      wire nbrOk = ((dUp < dDn) ? dUp : dDn) < {4'h0, nbrTh};
      wire midMc = midBand && checks && angle90 && tightOk
                && (isMed || nbrOk);
      wire [7:0] im = ((lowBand && checks) || midMc) ? mc : sdi;
      wire [16:0] bSum = im * wHi + tdi * wLo;
      wire [16:0] bSh = bSum >> stmmShift;
      wire [7:0] blend = (bSh > `PIX_MAX) ? 8'hFF : bSh[7:0];
      assign laneOut[gl*8 +: 8] = (motionMeasure < stmmMin) ? tdi
        : (motionMeasure > stmmMax) ? im : blend;
    end
  endgenerate

  // Register bus
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      thr_r <= `THRESH_RST;
      cat_r <= `CAT_RST;
      bld_r <= `BLEND_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case ({awAddr_r[7:2], 2'h0})
          `REG_THRESH: thr_r <= merge(thr_r, wData_r, wStrb_r)
                               & `THRESH_MASK;
          `REG_CAT: cat_r <= merge(cat_r, wData_r, wStrb_r) & `CAT_MASK;
          `REG_BLEND: bld_r <= merge(bld_r, wData_r, wStrb_r)
                               & `BLEND_MASK;
          `REG_STATUS: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          `REG_THRESH: s_axi_rdata <= thr_r;
          `REG_CAT: s_axi_rdata <= cat_r;
          `REG_BLEND: s_axi_rdata <= bld_r;
          `REG_STATUS: s_axi_rdata <= {14'h0000, state_r, 3'h0, blkCost_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Block sequencer
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cThr_r <= `THRESH_RST;
      cCat_r <= `CAT_RST;
      cBld_r <= `BLEND_RST;
      pairMv_r <= 8'h00;
      pairSad_r <= 13'h0000;
      blkCost_r <= 13'h0000;
      blkBusy <= 1'b0;
      blkDone <= 1'b0;
      winReady <= 1'b0;
      pixReady <= 1'b0;
      pairIdx <= 5'h00;
      candIdx <= 4'h0;
      fetchMv <= 8'h00;
      outValid <= 1'b0;
      outPix <= 16'h0000;
      outPair <= 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        mvTab[i] <= 8'h00;
      end
    end else begin
      blkDone <= 1'b0;
      outValid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (blkStart) begin
            cThr_r <= thr_r;
            cCat_r <= cat_r;
            cBld_r <= bld_r;
            state_r <= ST_SEARCH;
            blkBusy <= 1'b1;
            winReady <= 1'b1;
            pairIdx <= 5'h00;
            candIdx <= 4'h0;
            fetchMv <= CAND_TAB[7:0];
          end
        end
        ST_SEARCH: begin
          if (winValid) begin
            pairMv_r <= winMv;
            pairSad_r <= winSad;
            blkCost_r <= blkNext;
            candIdx <= candInc;
            fetchMv <= CAND_TAB[candInc*8 +: 8];
            if (candIdx == `LAST_CAND) begin
              mvTab[pairIdx] <= winMv;
              pairIdx <= pairInc;
              if (pairIdx == `LAST_PAIR) begin
                state_r <= ST_INTERP;
                winReady <= 1'b0;
                pixReady <= 1'b1;
                fetchMv <= mvTab[0];
              end
            end
          end
        end
        ST_INTERP: begin
          if (pixValid) begin
            outValid <= 1'b1;
            outPix <= laneOut;
            outPair <= pairIdx;
            pairIdx <= pairInc;
            fetchMv <= mvTab[pairInc];
            if (pairIdx == `LAST_PAIR) begin
              state_r <= ST_IDLE;
              pixReady <= 1'b0;
              blkBusy <= 1'b0;
              blkDone <= 1'b1;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
          winReady <= 1'b0;
          pixReady <= 1'b0;
          blkBusy <= 1'b0;
        end
      endcase
    end
  end

endmodule // motion_comp_deinterlacer

`default_nettype wire

/* File: rtl/motion_comp_deinterlacer_defines.vh */
// Offsets, field positions, reset values and tables of the deinterlacer
// Included by the top design file under rtl/ and by the checker; definitions only
`ifndef MOTION_COMP_DEINTERLACER_DEFINES_VH
`define MOTION_COMP_DEINTERLACER_DEFINES_VH

// Register byte offsets
`define REG_THRESH 8'h00
`define REG_CAT 8'h04
`define REG_BLEND 8'h08
`define REG_STATUS 8'h0C

// Reset values and writable masks
`define THRESH_RST 32'h00A5_0119
`define THRESH_MASK 32'h00FF_333F
`define CAT_RST 32'h0000_0A5A
`define CAT_MASK 32'h0000_0FFF
`define BLEND_RST 32'h0007_A020
`define BLEND_MASK 32'h000F_FFFF

// Field positions
`define F_CONS 0
`define F_SMTH 8
`define F_LCT 12
`define F_TGT 16
`define F_NBR 20
`define F_SLOPE 0
`define F_LOWP 4
`define F_HIGHP 8
`define F_SMIN 0
`define F_SMAX 8
`define F_SHIFT 16
`define F_STATE 16

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Search and decision constants
`define CAT_MULT 5'h1E
`define LAST_CAND 4'hF
`define LAST_PAIR 5'h1F
`define PIX_MAX 17'h000FF
// Candidate {mx,my} bytes, candidate 0 in the low byte
`define CAND_TABLE 128'h1202F240_30201000_F0E0D0C0_B01E0EFE

`endif

/* File: rtl/sad_window.v */
// Sum of absolute differences over one 6x5 comparison window
// Assumes both windows are packed pixel 0 in the low byte, same order
`default_nettype none

module sad_window (
  // Windows
  input wire [239:0] refWin,
  input wire [239:0] curWin,
  // Cost
  output wire [12:0] sad
);

  wire [12:0] acc [0:30];

  assign acc[0] = 13'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < 30; gi = gi + 1) begin : g_pix
      wire [7:0] a = refWin[gi*8 +: 8];
      wire [7:0] b = curWin[gi*8 +: 8];
      wire [7:0] d = (a > b) ? (a - b) : (b - a);
      assign acc[gi+1] = acc[gi] + {5'h00, d};
    end
  endgenerate

  assign sad = acc[30];

endmodule // sad_window

`default_nettype wire

/* File: tb/motion_comp_deinterlacer_checker.sv */
// Checker of the deinterlacer ports: bus answers, search and interp
// Assumes one clock domain; bound to the top module below
`default_nettype none
`include "motion_comp_deinterlacer_defines.vh"
module motion_comp_deinterlacer_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Block and streams
  input wire logic blkBusy,
  input wire logic blkDone,
  input wire logic winValid,
  input wire logic winReady,
  input wire logic [4:0] pairIdx,
  input wire logic [3:0] candIdx,
  input wire logic [7:0] fetchMv,
  input wire logic pixValid,
  input wire logic pixReady,
  input wire logic outValid,
  input wire logic [4:0] outPair
);
  localparam logic [127:0] CandTable = `CAND_TABLE;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence winTake;
    winValid && winReady;
  endsequence
  sequence pixTake;
    pixValid && pixReady;
  endsequence
  sequence lastWin;
    winTake and (candIdx == 4'hF && pairIdx == 5'h1F);
  endsequence
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  cand_vector_a: assert property (winReady |->
    fetchMv == CandTable[{candIdx, 3'b000}+:8]) else $error("bad vector");
  cand_step_a: assert property (winTake and (candIdx != 4'hF) |=>
    candIdx == $past(candIdx) + 4'h1) else $error("candidate skipped");
  search_end_a: assert property (lastWin |=>
    !winReady && pixReady && pairIdx == 5'h00) else $error("search end");
  result_pair_a: assert property (pixTake |=>
    outValid && outPair == $past(pairIdx)) else $error("result late");
  block_end_a: assert property (pixTake and (pairIdx == 5'h1F) |=>
    blkDone && !blkBusy && !pixReady) else $error("block end");
endmodule // motion_comp_deinterlacer_checker
bind motion_comp_deinterlacer motion_comp_deinterlacer_checker u_checker (
  .core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .blkBusy,
  .blkDone, .winValid, .winReady, .pairIdx, .candIdx, .fetchMv, .pixValid,
  .pixReady, .outValid, .outPair);
`default_nettype wire

/* File: tb/motion_comp_deinterlacer_tb.sv */
// Bench for the deinterlacer: registers, then whole blocks
// Assumes the fetch model answers windows for the shown vector
`default_nettype none
module motion_comp_deinterlacer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, blkStart, angle90, blkBusy, blkDone;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, winValid, winReady;
  logic pixValid, pixReady, outValid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, candIdx;
  logic [4:0] pairIdx, outPair;
  logic [7:0] s_axi_awaddr, s_axi_araddr, fetchMv, motionMeasure;
  logic [7:0] horizCplx, vertCplx, matchBias, missBias;
  logic [12:0] angleCost;
  logic [15:0] sdiPix, tdiPix, outPix;
  logic [31:0] s_axi_wdata, s_axi_rdata, oppEdge, vertNbr, seed;
  logic [63:0] refQuad, curQuad;
  logic [239:0] refWin, curWin;
  int checks, n_errors;
  motion_comp_deinterlacer u_motion_comp_deinterlacer (.core_clk, .rstn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .blkStart, .blkBusy,
    .blkDone, .winValid, .winReady, .refWin, .curWin, .pairIdx, .candIdx,
    .fetchMv, .pixValid, .pixReady, .refQuad, .curQuad, .oppEdge, .vertNbr,
    .sdiPix, .tdiPix, .motionMeasure, .angle90, .horizCplx, .vertCplx,
    .angleCost, .outValid, .outPix, .outPair);
  upstream_fetch_model u_upstream_fetch_model (.core_clk, .rstn, .winReady,
    .fetchMv, .matchBias, .missBias, .winValid, .refWin, .curWin, .pixReady,
    .pixValid);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Blend of the chosen result and the temporal pixel
  function automatic logic [7:0] expPix(input int im, t, m);
    int v;
    v = (im * (m - 32) + t * (160 - m)) >> 7;
    if (m < 32) return 8'(t);
    if (m > 160) return 8'(im);
    return v > 255 ? 8'hFF : 8'(v);
  endfunction
  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 4000) begin
      n_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      conclude();
    end
  endtask
  // Ready comes after a random delay, then holds until the answer
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] rsp);
    int n, dly;
    dly = int'(rnd() & 32'h0000_0003);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (n >= dly) s_axi_rready <= 1'b1;
    end
    guard(n);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, d);
    check({30'h0, s_axi_rresp}, {30'h0, rsp});
    @(posedge core_clk);
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] rsp);
    int n, dly;
    dly = int'(rnd() & 32'h0000_0003);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (n >= dly) s_axi_bready <= 1'b1;
    end
    guard(n);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, rsp});
    @(posedge core_clk);
  endtask
  // One block: lo is the cost bias of vector zero, hi of the others
  task automatic runBlock(input int lo, hi, input bit cons, a90,
      input logic [7:0] m);
    int n, got;
    logic [31:0] r;
    logic [7:0] e;
    r = rnd();
    matchBias <= 8'(lo);
    missBias <= 8'(hi);
    angle90 <= a90;
    motionMeasure <= m;
    refQuad <= {r[31:8], r[7:0], r[31:8], r[7:0]};
    curQuad <= {r[23:0], r[7:0], r[23:0], r[7:0]};
    oppEdge <= cons ? 32'hC800_C800 : 32'h0000_0000;
    vertNbr <= {4{r[7:0]}};
    sdiPix <= {2{r[15:8]}};
    tdiPix <= {2{r[23:16]}};
    e = expPix((cons && lo != hi && (lo == 0 || (lo < 5 && a90))) ?
      r[7:0] : r[15:8], r[23:16], m);
    blkStart <= 1'b1;
    @(posedge core_clk);
    blkStart <= 1'b0;
    got = 0;
    for (n = 0; n < 4000; n++) begin
      @(posedge core_clk);
      if (pixValid && pixReady) check(fetchMv, lo == hi ? 8'h12 : 8'h00);
      if (outValid) begin
        check(outPix, {e, e});
        got++;
      end
      if (blkDone) break;
    end
    guard(n);
    check(32'(got), 32'd32);
    axiRead(8'h0C, 32'(30 * lo), 2'h0);
  endtask
  initial begin
    logic [31:0] r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
      s_axi_rready, blkStart, angle90} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, motionMeasure, matchBias,
      missBias, refQuad, curQuad, oppEdge, vertNbr, sdiPix, tdiPix} = '0;
    s_axi_wstrb = 4'hF;
    horizCplx = 8'h0A;
    vertCplx = 8'h0A;
    angleCost = 13'h1FFF;
    seed = 32'hD417;
    checks = 0;
    n_errors = 0;
    rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    axiRead(8'h00, 32'h00A5_0119, 2'h0);
    axiRead(8'h04, 32'h0000_0A5A, 2'h0);
    axiRead(8'h08, 32'h0007_A020, 2'h0);
    axiRead(8'h10, 32'h0000_0000, 2'h2);
    axiWrite(8'h10, 32'hFFFF_FFFF, 2'h2);
    axiWrite(8'h0C, 32'hFFFF_FFFF, 2'h0);
    axiRead(8'h0C, 32'h0000_0000, 2'h0);
    axiWrite(8'h04, 32'hFFFF_FFFF, 2'h0);
    axiRead(8'h04, 32'h0000_0FFF, 2'h0);
    axiWrite(8'h04, 32'h0000_0A5A, 2'h0);
    runBlock(0, 0, 1, 1, 8'hF0);
    runBlock(0, 3, 1, 1, 8'hF0);
    runBlock(0, 2, 0, 1, 8'hF0);
    runBlock(2, 4, 1, 1, 8'hF0);
    runBlock(2, 4, 1, 0, 8'hF0);
    runBlock(5, 6, 1, 1, 8'hF0);
    runBlock(0, 1, 1, 1, 8'h10);
    repeat (6) begin
      r = rnd();
      runBlock(int'(r[3:0]) % 6, int'(r[3:0]) % 6 + int'(r[4]), r[5], r[6],
        r[15:8]);
    end
    conclude();
  end
endmodule // motion_comp_deinterlacer_tb
`default_nettype wire

/* File: tb/upstream_fetch_model.sv */
// Upstream fetch model: windows for the shown vector, valid handshakes
// Assumes the bench sets both bias inputs before each block
`default_nettype none
module upstream_fetch_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Search window
  input wire logic winReady,
  input wire logic [7:0] fetchMv,
  input wire logic [7:0] matchBias,
  input wire logic [7:0] missBias,
  output logic winValid,
  output logic [239:0] refWin,
  output logic [239:0] curWin,
  // Interp handshake
  input wire logic pixReady,
  output logic pixValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rng;
  logic [7:0] bias;
  assign bias = (fetchMv == 8'h00) ? matchBias : missBias;
  // Cost is bias times thirty pixels; inverted when idle
  always_comb begin
    for (int k = 0; k < 30; k++) begin
      curWin[8*k+:8] = (8'h40 + 8'(k)) ^ {8{!winValid}};
      refWin[8*k+:8] = (8'h40 + 8'(k) + bias) ^ {8{!winValid}};
    end
  end
  // Valid held until taken, random stalls
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rng <= 32'h0000_1D5B;
      winValid <= 1'b0;
      pixValid <= 1'b0;
    end else begin
      rng <= {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
      if (!winValid || winReady) winValid <= rng[0] | rng[3];
      if (!pixValid || pixReady) pixValid <= rng[1] | rng[4];
    end
  end
endmodule // upstream_fetch_model
`default_nettype wire
